/* core/link_ctrl_pkg.sv */
// Purpose: Shared constants and types for the display link control block.
// Assumes: System clock of 20 MHz.
// Notes:   Lane pair states are written {p, n}.
package link_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int LP_SYMBOL_NS  = 100;
  localparam int LP_SYMBOL_RAW = (LP_SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LP_SYMBOL_CYC = (LP_SYMBOL_RAW < 1) ? 1 : LP_SYMBOL_RAW;
  localparam logic [7:0] LP_HOLD_LAST = 8'(LP_SYMBOL_CYC - 1);
  localparam int CLK_IDLE_NS   = 1000;
  localparam int CLK_IDLE_RAW  = CLK_IDLE_NS / CLK_PERIOD_NS;
  localparam int CLK_IDLE_CYC  = (CLK_IDLE_RAW < 1) ? 1 : CLK_IDLE_RAW;
  localparam logic [15:0] CLK_IDLE_LAST = 16'(CLK_IDLE_CYC - 1);

  // ----------------------------------------------------------------------
  // Lanes and bytes
  // ----------------------------------------------------------------------
  localparam int MIN_LANES = 1;
  localparam int MAX_LANES = 4;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ----------------------------------------------------------------------
  // Low-power pair states
  // ----------------------------------------------------------------------
  localparam logic [1:0] LS_STOP   = 2'h3;
  localparam logic [1:0] LS_HI_P   = 2'h2;
  localparam logic [1:0] LS_HI_N   = 2'h1;
  localparam logic [1:0] LS_BRIDGE = 2'h0;

  // ----------------------------------------------------------------------
  // Last step of each transmit phase
  // ----------------------------------------------------------------------
  localparam logic [3:0] STEP_ENTRY_LAST = 4'h3;
  localparam logic [3:0] STEP_BITS_LAST  = 4'hF;
  localparam logic [3:0] STEP_EXIT_LAST  = 4'h1;
  localparam logic [3:0] STEP_TA_LAST    = 4'h3;

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_REQ  = 2'b01,
    HS_ON   = 2'b10
  } hs_seq_t;

  typedef enum logic [3:0] {
    ST_LISTEN   = 4'b0000,
    ST_RX_S1    = 4'b0001,
    ST_RX_S2    = 4'b0010,
    ST_RX_ESC3  = 4'b0011,
    ST_RX_TA3   = 4'b0100,
    ST_ESC_CMD  = 4'b0101,
    ST_ESC_DATA = 4'b0110,
    ST_ESC_WAIT = 4'b0111,
    ST_ULPS     = 4'b1000,
    ST_OWN_IDLE = 4'b1001,
    ST_TX_ENTRY = 4'b1010,
    ST_TX_CMD   = 4'b1011,
    ST_TX_DATA  = 4'b1100,
    ST_TX_EXIT  = 4'b1101,
    ST_TX_TA    = 4'b1110
  } link_state_t;

endpackage : link_ctrl_pkg

/* core/lane_link_if.sv */
// Purpose: Carries one data lane's receive results to the link controller.
// Assumes: Everything here runs on the system clock.
// Notes:   The controller supplies the shared bit clock edge.
`timescale 1ns/1ps
interface lane_link_if;
  logic       ser_clk_rise;
  logic [1:0] lp_state;
  logic       hs_active;
  logic [7:0] rx_byte;
  logic       rx_strobe;

  modport lane (input ser_clk_rise, output lp_state, hs_active, rx_byte, rx_strobe);
  modport ctrl (output ser_clk_rise, input lp_state, hs_active, rx_byte, rx_strobe);
endinterface : lane_link_if

/* core/lane_rx.sv */
// Purpose: One data lane receiver: pin sync, burst detect, bytes.
// Assumes: Bit clock edges come pre-synchronised over the interface.
// Notes:   Bits are taken LSB first, one per rising bit clock edge.
`timescale 1ns/1ps
module lane_rx
  import link_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  // Lane pins.
  input  wire logic [1:0] lp_pair_i,
  input  wire logic       ser_dat_i,
  // Controller side.
  lane_link_if.lane       lnk
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] lp_meta_ff;
  logic [1:0] lp_sync_ff;
  logic [1:0] lp_prev_ff;
  logic       dat_meta_ff;
  logic       dat_sync_ff;
  hs_seq_t    hs_ff;
  hs_seq_t    nxt_hs;
  logic [7:0] shreg_ff;
  logic [7:0] byte_ff;
  logic [2:0] bit_cnt_ff;
  logic       strobe_ff;

  // Two stages before any logic reads a pin.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lp_meta_ff  <= LS_STOP;
      lp_sync_ff  <= LS_STOP;
      lp_prev_ff  <= LS_STOP;
      dat_meta_ff <= 1'b0;
      dat_sync_ff <= 1'b0;
    end
    else
    begin
      lp_meta_ff  <= lp_pair_i;
      lp_sync_ff  <= lp_meta_ff;
      lp_prev_ff  <= lp_sync_ff;
      dat_meta_ff <= ser_dat_i;
      dat_sync_ff <= dat_meta_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Burst entry: stop, then HI_N, then bridge; any stop ends the burst
  // ----------------------------------------------------------------------
  wire lp_chg_w   = (lp_sync_ff != lp_prev_ff);
  wire bit_take_w = (hs_ff == HS_ON) && lnk.ser_clk_rise;
  wire byte_end_w = bit_take_w && (bit_cnt_ff == BIT_LAST);
  wire [7:0] next_shreg_w = {dat_sync_ff, shreg_ff[7:1]};

  // Burst entry tracker.
  always_comb
  begin
    nxt_hs = hs_ff;
    if (lp_sync_ff == LS_STOP)
      nxt_hs = HS_IDLE;
    else if (lp_chg_w)
    begin
      case (hs_ff)
        HS_IDLE: if (lp_sync_ff == LS_HI_N && lp_prev_ff == LS_STOP) nxt_hs = HS_REQ;
        HS_REQ:  nxt_hs = (lp_sync_ff == LS_BRIDGE) ? HS_ON : HS_IDLE;
        default: nxt_hs = hs_ff;
      endcase
    end
  end

  // Bit counter restarts with each burst so bytes stay whole.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hs_ff      <= HS_IDLE;
      shreg_ff   <= 8'h00;
      byte_ff    <= 8'h00;
      bit_cnt_ff <= 3'h0;
      strobe_ff  <= 1'b0;
    end
    else
    begin
      hs_ff     <= nxt_hs;
      strobe_ff <= byte_end_w;
      if (hs_ff != HS_ON)
        bit_cnt_ff <= 3'h0;
      else if (bit_take_w)
      begin
        shreg_ff   <= next_shreg_w;
        bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
      end
      if (byte_end_w)
        byte_ff <= next_shreg_w;
    end
  end

  // Results towards the controller, all from flip-flops.
  assign lnk.lp_state  = lp_sync_ff;
  assign lnk.hs_active = (hs_ff == HS_ON);
  assign lnk.rx_byte   = byte_ff;
  assign lnk.rx_strobe = strobe_ff;

endmodule : lane_rx

/* core/serial_display_link_control.sv */
// Purpose: Peripheral-side link control for a serial display link.
// Assumes: Host drives the clock lane; lane pins sampled at 20 MHz.
// Notes:   Lane merging and error reporting live elsewhere.
`timescale 1ns/1ps
module serial_display_link_control
  import link_ctrl_pkg::*;
#(
  parameter int         NUM_LANES   = 4,
  parameter bit         LANE0_BIDIR = 1'b1,
  parameter logic [7:0] CMD_ULPS    = 8'h0F,
  parameter logic [7:0] CMD_LPDT    = 8'hF0
)
(
  // Clock and reset.
  input  wire logic                           sys_clk_i,
  input  wire logic                           sys_rst_i,
  // Link pins from the host.
  input  wire logic                           ser_clk_i,
  input  wire logic [2*MAX_LANES-1:0]         lane_lp_i,
  input  wire logic [MAX_LANES-1:0]           lane_dat_i,
  // Lane 0 reverse drive.
  output logic      [1:0]                     lane0_lp_o,
  output logic                                lane0_lp_oe_o,
  // Received data.
  output logic      [BYTE_BITS*MAX_LANES-1:0] hs_byte_o,
  output logic      [MAX_LANES-1:0]           hs_byte_valid_o,
  output logic      [7:0]                     lp_byte_o,
  output logic                                lp_byte_valid_o,
  // Direction control.
  output logic                                bus_turn_request_o,
  output logic                                bus_owned_o,
  input  wire logic                           give_back_i,
  // Reply stream.
  input  wire logic [7:0]                     reply_byte_i,
  input  wire logic                           reply_valid_i,
  input  wire logic                           reply_last_i,
  output logic                                reply_ready_o,
  // Status.
  output logic                                ultra_low_power_o,
  output logic                                clk_stopped_o
);

  // ----------------------------------------------------------------------
  // Lane count, clamped to the legal range
  // ----------------------------------------------------------------------
  localparam int LANES = (NUM_LANES < MIN_LANES) ? MIN_LANES :
                         (NUM_LANES > MAX_LANES) ? MAX_LANES : NUM_LANES;

  // ----------------------------------------------------------------------
  // Bit clock sync; the clock lane is input only here
  // ----------------------------------------------------------------------
  logic        clk_meta_ff;
  logic        clk_sync_ff;
  logic        clk_prev_ff;
  logic [15:0] idle_cnt_ff;
  logic        clk_stopped_ff;

  wire clk_rise_w = clk_sync_ff & ~clk_prev_ff;

  // The clock lane pin is sampled and never driven.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      clk_meta_ff <= 1'b0;
      clk_sync_ff <= 1'b0;
      clk_prev_ff <= 1'b0;
    end
    else
    begin
      clk_meta_ff <= ser_clk_i;
      clk_sync_ff <= clk_meta_ff;
      clk_prev_ff <= clk_sync_ff;
    end
  end

  // A stopped clock shows the host chose non-continuous mode.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      idle_cnt_ff    <= 16'h0000;
      clk_stopped_ff <= 1'b0;
    end
    else
    begin
      if (clk_rise_w)
        idle_cnt_ff <= 16'h0000;
      else if (idle_cnt_ff != CLK_IDLE_LAST)
        idle_cnt_ff <= 16'(idle_cnt_ff + 16'h0001);
      clk_stopped_ff <= (idle_cnt_ff == CLK_IDLE_LAST);
    end
  end

  // ----------------------------------------------------------------------
  // Lane receivers; all lanes are receive only except lane 0
  // ----------------------------------------------------------------------
  lane_link_if lnk [MAX_LANES] ();
  logic [BYTE_BITS*MAX_LANES-1:0] hs_byte_ff;
  logic [MAX_LANES-1:0]           hs_valid_ff;

  for (genvar g = 0; g < MAX_LANES; g++)
  begin : g_lane
    localparam bit LANE_ON = (g < LANES);

    assign lnk[g].ser_clk_rise = clk_rise_w;

    lane_rx u_lane_rx (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .lp_pair_i (lane_lp_i[2*g+1:2*g]),
      .ser_dat_i (lane_dat_i[g]),
      .lnk       (lnk[g])
    );

    // No ready exists: every byte of a lane below LANES is taken the cycle it appears; other lanes' bytes are dropped.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
      begin
        hs_byte_ff[BYTE_BITS*g +: BYTE_BITS] <= 8'h00;
        hs_valid_ff[g]                       <= 1'b0;
      end
      else
      begin
        hs_valid_ff[g] <= LANE_ON & lnk[g].rx_strobe;
        if (LANE_ON && lnk[g].rx_strobe)
          hs_byte_ff[BYTE_BITS*g +: BYTE_BITS] <= lnk[g].rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Lane 0 low-power decode and reverse drive
  // ----------------------------------------------------------------------
  link_state_t state_ff;
  link_state_t nxt_state;
  logic [1:0]  lp0_prev_ff;
  logic [3:0]  step_ff;
  logic [3:0]  nxt_step;
  logic [7:0]  hold_ff;
  logic [7:0]  nxt_hold;
  logic [7:0]  rx_bits_ff;
  logic [7:0]  nxt_bits;
  logic [2:0]  rx_cnt_ff;
  logic [2:0]  nxt_cnt;
  logic [7:0]  tx_shreg_ff;
  logic [7:0]  nxt_txb;
  logic        more_ff;
  logic        nxt_more;
  logic        nxt_turn;
  logic        nxt_lpv;
  logic [7:0]  nxt_lpb;
  logic        nxt_ready;
  logic [1:0]  lane0_lp_ff;
  logic        lane0_oe_ff;
  logic        turn_ff;
  logic        lpv_ff;
  logic [7:0]  lpb_ff;
  logic        ready_ff;
  logic        owned_ff;
  logic        ulps_ff;

  // Symbol decode of the lane 0 pair.
  wire [1:0] lp0_w     = lnk[0].lp_state;
  wire       sym_new_w = (lp0_w != lp0_prev_ff);
  wire       stop_w    = sym_new_w && (lp0_w == LS_STOP);
  wire       bit_sym_w = sym_new_w && (lp0_w == LS_HI_P || lp0_w == LS_HI_N);
  wire [7:0] full_w    = {(lp0_w == LS_HI_P), rx_bits_ff[7:1]};
  wire       own_w     = (state_ff >= ST_OWN_IDLE);
  wire       tx_w      = (state_ff >= ST_TX_ENTRY);

  // Transmit step timing; each symbol stands for a whole hold period.
  wire       sym_done_w = tx_w && (hold_ff == LP_HOLD_LAST);
  wire [3:0] step_last_w = (state_ff == ST_TX_ENTRY) ? STEP_ENTRY_LAST :
                           (state_ff == ST_TX_EXIT)  ? STEP_EXIT_LAST  :
                           (state_ff == ST_TX_TA)    ? STEP_TA_LAST    : STEP_BITS_LAST;
  wire       phase_end_w = sym_done_w && (step_ff == step_last_w);

  // Symbol selection; only low-power states are ever produced.
  wire       bit_src_w   = (state_ff == ST_TX_CMD) ? CMD_LPDT[step_ff[3:1]] :
                                                     tx_shreg_ff[step_ff[3:1]];
  wire [1:0] entry_sym_w = step_ff[0] ? LS_BRIDGE : (step_ff[1] ? LS_HI_N : LS_HI_P);
  wire [1:0] bits_sym_w  = step_ff[0] ? LS_BRIDGE : (bit_src_w ? LS_HI_P : LS_HI_N);
  wire [1:0] exit_sym_w  = step_ff[0] ? LS_STOP : LS_HI_P;
  wire [1:0] ta_sym_w    = step_ff[0] ? LS_BRIDGE : LS_HI_P;
  wire [1:0] drive_sym_w = (state_ff == ST_TX_ENTRY) ? entry_sym_w :
                           (state_ff == ST_TX_CMD ||
                            state_ff == ST_TX_DATA)  ? bits_sym_w  :
                           (state_ff == ST_TX_EXIT)  ? exit_sym_w  :
                           (state_ff == ST_TX_TA)    ? ta_sym_w    : LS_STOP;

  // Link state machine.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_step  = step_ff;
    nxt_hold  = hold_ff;
    nxt_bits  = rx_bits_ff;
    nxt_cnt   = rx_cnt_ff;
    nxt_txb   = tx_shreg_ff;
    nxt_more  = more_ff;
    nxt_turn  = 1'b0;
    nxt_lpv   = 1'b0;
    nxt_lpb   = lpb_ff;
    nxt_ready = 1'b0;
    if (tx_w)
    begin
      nxt_hold = sym_done_w ? 8'h00 : 8'(hold_ff + 8'h01);
      if (sym_done_w)
        nxt_step = (step_ff == step_last_w) ? 4'h0 : 4'(step_ff + 4'h1);
    end
    case (state_ff)
      ST_LISTEN:
        if (sym_new_w && lp0_w == LS_HI_P && lp0_prev_ff == LS_STOP)
          nxt_state = ST_RX_S1;
      ST_RX_S1:
        if (sym_new_w)
          nxt_state = (lp0_w == LS_BRIDGE) ? ST_RX_S2 : ST_LISTEN;
      ST_RX_S2:
        if (sym_new_w)
        begin
          if (lp0_w == LS_HI_N)
            nxt_state = ST_RX_ESC3;
          else if (lp0_w == LS_HI_P && LANE0_BIDIR)
            nxt_state = ST_RX_TA3;
          else
            nxt_state = ST_LISTEN;
        end
      ST_RX_ESC3:
        if (sym_new_w)
        begin
          nxt_state = (lp0_w == LS_BRIDGE) ? ST_ESC_CMD : ST_LISTEN;
          nxt_cnt   = 3'h0;
        end
      ST_RX_TA3:
        if (sym_new_w)
        begin
          nxt_state = (lp0_w == LS_BRIDGE) ? ST_OWN_IDLE : ST_LISTEN;
          nxt_turn  = (lp0_w == LS_BRIDGE);
        end
      ST_ESC_CMD, ST_ESC_DATA:
        if (stop_w)
          nxt_state = ST_LISTEN;
        else if (bit_sym_w)
        begin
          nxt_bits = full_w;
          nxt_cnt  = 3'(rx_cnt_ff + 3'h1);
          if (rx_cnt_ff == BIT_LAST && state_ff == ST_ESC_DATA)
          begin
            nxt_lpb = full_w;
            nxt_lpv = 1'b1;
          end
          else if (rx_cnt_ff == BIT_LAST)
            nxt_state = (full_w == CMD_ULPS) ? ST_ULPS :
                        (full_w == CMD_LPDT) ? ST_ESC_DATA : ST_ESC_WAIT;
        end
      ST_ESC_WAIT, ST_ULPS:
        if (stop_w)
          nxt_state = ST_LISTEN;
      ST_OWN_IDLE:
        if (reply_valid_i)
        begin
          nxt_txb   = reply_byte_i;
          nxt_more  = ~reply_last_i;
          nxt_ready = 1'b1;
          nxt_state = ST_TX_ENTRY;
          nxt_step  = 4'h0;
          nxt_hold  = 8'h00;
        end
        else if (give_back_i)
        begin
          nxt_state = ST_TX_TA;
          nxt_step  = 4'h0;
          nxt_hold  = 8'h00;
        end
      ST_TX_ENTRY:
        if (phase_end_w)
          nxt_state = ST_TX_CMD;
      ST_TX_CMD:
        if (phase_end_w)
          nxt_state = ST_TX_DATA;
      ST_TX_DATA:
        if (phase_end_w && more_ff && reply_valid_i)
        begin
          nxt_txb   = reply_byte_i;
          nxt_more  = ~reply_last_i;
          nxt_ready = 1'b1;
        end
        else if (phase_end_w)
          nxt_state = ST_TX_EXIT;
      ST_TX_EXIT:
        if (phase_end_w)
          nxt_state = ST_OWN_IDLE;
      ST_TX_TA:
        if (phase_end_w)
          nxt_state = ST_LISTEN;
      default:
        nxt_state = ST_LISTEN;
    endcase
  end

  // State registers.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_ff    <= ST_LISTEN;
      lp0_prev_ff <= LS_STOP;
      step_ff     <= 4'h0;
      hold_ff     <= 8'h00;
      rx_bits_ff  <= 8'h00;
      rx_cnt_ff   <= 3'h0;
      tx_shreg_ff <= 8'h00;
      more_ff     <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      lp0_prev_ff <= lp0_w;
      step_ff     <= nxt_step;
      hold_ff     <= nxt_hold;
      rx_bits_ff  <= nxt_bits;
      rx_cnt_ff   <= nxt_cnt;
      tx_shreg_ff <= nxt_txb;
      more_ff     <= nxt_more;
    end
  end

  // Output registers; the drive lags the state by one cycle.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lane0_lp_ff <= LS_STOP;
      lane0_oe_ff <= 1'b0;
      turn_ff     <= 1'b0;
      lpv_ff      <= 1'b0;
      lpb_ff      <= 8'h00;
      ready_ff    <= 1'b0;
      owned_ff    <= 1'b0;
      ulps_ff     <= 1'b0;
    end
    else
    begin
      lane0_lp_ff <= drive_sym_w;
      lane0_oe_ff <= own_w;
      turn_ff     <= nxt_turn;
      lpv_ff      <= nxt_lpv;
      lpb_ff      <= nxt_lpb;
      ready_ff    <= nxt_ready;
      owned_ff    <= own_w;
      ulps_ff     <= (state_ff == ST_ULPS);
    end
  end

  // Ports straight from flip-flops.
  assign lane0_lp_o         = lane0_lp_ff;
  assign lane0_lp_oe_o      = lane0_oe_ff;
  assign hs_byte_o          = hs_byte_ff;
  assign hs_byte_valid_o    = hs_valid_ff;
  assign lp_byte_o          = lpb_ff;
  assign lp_byte_valid_o    = lpv_ff;
  assign bus_turn_request_o = turn_ff;
  assign bus_owned_o        = owned_ff;
  assign reply_ready_o      = ready_ff;
  assign ultra_low_power_o  = ulps_ff;
  assign clk_stopped_o      = clk_stopped_ff;

endmodule : serial_display_link_control

/* tb/link_ctrl_properties.sv */
// Purpose: Pin-level checks for the link controller.
// Assumes: One clock; asynchronous active-high reset.
// Notes:   Bound to the top module by the bench.
`timescale 1ns/1ps
module link_ctrl_properties
  import link_ctrl_pkg::*;
#(parameter int NUM_LANES = 4)
(
  // Clock and reset.
  input wire logic                 sys_clk_i,
  input wire logic                 sys_rst_i,
  // Watched pins.
  input wire logic                 ser_clk_i,
  input wire logic [1:0]           lane0_lp_o,
  input wire logic                 lane0_lp_oe_o,
  input wire logic [MAX_LANES-1:0] hs_byte_valid_o,
  input wire logic                 lp_byte_valid_o,
  input wire logic                 bus_turn_request_o,
  input wire logic                 bus_owned_o,
  input wire logic                 reply_ready_o,
  input wire logic                 clk_stopped_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // A reply opens with two cycles of 10 and then a bridge.
  sequence entry_s;
    (lane0_lp_o == 2'b10) [*2] ##1 (lane0_lp_o == 2'b00);
  endsequence
  owned_oe_a: assert property (lane0_lp_oe_o == bus_owned_o)
    else $error("owner flag differs from drive");
  idle_stop_a: assert property (!lane0_lp_oe_o |-> lane0_lp_o == 2'b11)
    else $error("released lane not at stop");
  turn_pulse_a: assert property (bus_turn_request_o |=> !bus_turn_request_o)
    else $error("turn request too long");
  turn_owns_a: assert property ($rose(bus_turn_request_o) |=> $rose(lane0_lp_oe_o))
    else $error("turn request without taking lane");
  ready_owned_a: assert property (reply_ready_o |-> bus_owned_o)
    else $error("reply taken while not owner");
  reply_entry_a: assert property (reply_ready_o && lane0_lp_o == 2'b11 |=> entry_s)
    else $error("reply entry wrong");
  lanes_unused_a: assert property ((hs_byte_valid_o >> NUM_LANES) == '0)
    else $error("unused lane gave a byte");
  hs_pulse_a: assert property (|hs_byte_valid_o |=> !(|hs_byte_valid_o))
    else $error("byte pulse too long");
  lp_pulse_a: assert property (lp_byte_valid_o |=> (!lp_byte_valid_o) [*2])
    else $error("escape byte pulse too long");
  clk_alive_a: assert property ($rose(ser_clk_i) |-> ##[1:6] !clk_stopped_o)
    else $error("stop flag with clock running");
endmodule : link_ctrl_properties

/* tb/host_link_model.sv */
// Purpose: Host end of the link: bit clock, lane pairs, data.
// Assumes: Each level outlasts the device's three-cycle pin path.
// Notes:   The bit clock stands still outside bursts.
`timescale 1ns/1ps
module host_link_model
(
  // Clock.
  input  wire logic       sys_clk_i,
  // Link pins.
  output logic            ser_clk_o,
  output logic [7:0]      lane_lp_o,
  output logic [3:0]      lane_dat_o
);
  // Only this model drives the clock pin; lanes rest at stop.
  initial
  begin
    ser_clk_o  = 1'b0;
    lane_lp_o  = 8'hFF;
    lane_dat_o = 4'h0;
  end
  // One lane 0 symbol, slow enough for the device's clock.
  task automatic pairs(input logic [1:0] p);
    @(posedge sys_clk_i);
    #1 lane_lp_o[1:0] = p;
    repeat (3) @(posedge sys_clk_i);
  endtask : pairs
  // Four symbols, first in the top bits.
  task automatic seq4(input logic [7:0] s);
    for (int i = 3; i >= 0; i--)
      pairs(s[2*i+:2]);
  endtask : seq4
  // Escape bits LSB first, each followed by a bridge.
  task automatic esc_byte(input logic [7:0] b);
    for (int i = 0; i < 16; i++)
      pairs(i[0] ? 2'b00 : {b[i/2], ~b[i/2]});
  endtask : esc_byte
  // Escape entry and command; the caller ends it with a stop.
  task automatic escape(input logic [7:0] cmd);
    seq4(8'h84);
    esc_byte(cmd);
  endtask : escape
  // Handover from stop; the host then lets go of lane 0.
  task automatic handover();
    seq4(8'h88);
    repeat (4) @(posedge sys_clk_i);
    #1 lane_lp_o[1:0] = 2'b11;
  endtask : handover
  // A burst of n bytes per lane; the clock toggles only inside it.
  task automatic burst(input logic [31:0] w, input int n);
    @(posedge sys_clk_i);
    #1 lane_lp_o = 8'h55;
    repeat (4) @(posedge sys_clk_i);
    #1 lane_lp_o = 8'h00;
    for (int k = 0; k < 8*n; k++)
    begin
      repeat (3) @(posedge sys_clk_i);
      #1 ser_clk_o = 1'b0;
      for (int g = 0; g < 4; g++)
        lane_dat_o[g] = w[8*g+k%8];
      repeat (3) @(posedge sys_clk_i);
      #1 ser_clk_o = 1'b1;
    end
    repeat (3) @(posedge sys_clk_i);
    #1 ser_clk_o = 1'b0;
    lane_lp_o = 8'hFF;
    lane_dat_o = ~lane_dat_o;
    repeat (4) @(posedge sys_clk_i);
  endtask : burst
endmodule : host_link_model

/* tb/tb_serial_display_link_control.sv */
// Purpose: Self-checking bench for the link controller.
// Assumes: 20 MHz clock; the host model drives the link.
// Notes:   Lane 3 lies beyond NUM_LANES and must stay silent.
`timescale 1ns/1ps
module tb_serial_display_link_control;
  import link_ctrl_pkg::*;
  localparam int          NUM_LANES = 3;
  localparam logic [7:0]  CMD_ULPS  = 8'h0F;
  localparam logic [7:0]  CMD_LPDT  = 8'hF0;
  localparam logic [31:0] WORD      = 32'hC381_5AA5;
  logic sys_clk_i, sys_rst_i, ser_clk_i, lane0_lp_oe_o, lp_byte_valid_o, bus_owned_o;
  logic bus_turn_request_o, give_back_i, reply_valid_i, reply_last_i, reply_ready_o;
  logic ultra_low_power_o, clk_stopped_o;
  logic [1:0] lane0_lp_o, prev_lp;
  logic [3:0] lane_dat_i, hs_byte_valid_o;
  logic [7:0] host_lp, lane_lp_i, lp_byte_o, reply_byte_i;
  logic [31:0] hs_byte_o, rev_bits;
  int failures, checked, lp_cnt, turn_cnt, ready_cnt, cycles;
  int hs_cnt [4];
  // Lane 0 carries whichever side drives it.
  assign lane_lp_i = {host_lp[7:2], (lane0_lp_oe_o === 1'b1) ? lane0_lp_o : host_lp[1:0]};
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  host_link_model host_link_model_inst (.sys_clk_i(sys_clk_i), .ser_clk_o(ser_clk_i),
    .lane_lp_o(host_lp), .lane_dat_o(lane_dat_i));
  serial_display_link_control #(.NUM_LANES(NUM_LANES), .CMD_ULPS(CMD_ULPS),
    .CMD_LPDT(CMD_LPDT)) serial_display_link_control_inst (.*);
  // Pulses are counted as they pass, since scenarios are busy driving then.
  always @(posedge sys_clk_i)
  begin
    cycles++;
    for (int g = 0; g < 4; g++)
      hs_cnt[g] += (hs_byte_valid_o[g] === 1'b1);
    lp_cnt += (lp_byte_valid_o === 1'b1);
    turn_cnt += (bus_turn_request_o === 1'b1);
    ready_cnt += (reply_ready_o === 1'b1);
    if (lane0_lp_oe_o === 1'b1 && lane0_lp_o !== prev_lp && ^lane0_lp_o === 1'b1)
      rev_bits = {lane0_lp_o[1], rev_bits[31:1]};
    prev_lp = lane0_lp_o;
    if (cycles == 4000)
    begin
      failures++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Two bytes back to back on every lane, then the clock goes quiet.
  task automatic t_burst();
    host_link_model_inst.burst(WORD, 2);
    for (int g = 0; g < 4; g++)
    begin
      check(hs_cnt[g], (g < NUM_LANES) ? 2 : 0);
      check(hs_byte_o[8*g+:8], (g < NUM_LANES) ? WORD[8*g+:8] : 8'h00);
    end
    repeat (25) @(posedge sys_clk_i);
    check(clk_stopped_o, 1'b1);
    $display("burst test done");
  endtask : t_burst
  // Data escape, then an unknown command whose data must be dropped.
  task automatic t_escape();
    host_link_model_inst.escape(CMD_LPDT);
    host_link_model_inst.esc_byte(8'h3C);
    host_link_model_inst.pairs(2'b11);
    host_link_model_inst.escape(8'h55);
    host_link_model_inst.esc_byte(8'hC3);
    host_link_model_inst.pairs(2'b11);
    check(lp_cnt, 1);
    check(lp_byte_o, 8'h3C);
    host_link_model_inst.escape(CMD_ULPS);
    repeat (4) @(posedge sys_clk_i);
    check(ultra_low_power_o, 1'b1);
    host_link_model_inst.pairs(2'b11);
    repeat (2) @(posedge sys_clk_i);
    check(ultra_low_power_o, 1'b0);
    $display("escape test done");
  endtask : t_escape
  // Handover, two reply bytes, then the bus goes back to the host.
  task automatic t_turn();
    host_link_model_inst.handover();
    check(turn_cnt, 1);
    check(bus_owned_o, 1'b1);
    rev_bits = '0;
    reply_valid_i = 1'b1;
    // Two bytes back to back; each stands until its own ready pulse is seen.
    for (int b = 0; b < 2; b++)
    begin
      reply_byte_i = WORD[8*b+:8];
      reply_last_i = (b == 1);
      for (int i = 0; i < 80 && (i == 0 || reply_ready_o !== 1'b1); i++)
        @(posedge sys_clk_i) #1;
    end
    reply_valid_i = 1'b0;
    reply_last_i = 1'b0;
    repeat (40) @(posedge sys_clk_i);
    check(rev_bits[31:5], {1'b1, WORD[15:0], CMD_LPDT, 2'b01});
    check(ready_cnt, 2);
    #1 give_back_i = 1'b1;
    for (int i = 0; i < 20 && bus_owned_o !== 1'b0; i++)
      @(posedge sys_clk_i) #1;
    give_back_i = 1'b0;
    check(bus_owned_o, 1'b0);
    check(lane0_lp_o, 2'b11);
    $display("turn test done");
  endtask : t_turn
  initial
  begin
    sys_rst_i = 1'b1;
    give_back_i = 1'b0;
    reply_byte_i = 8'h00;
    reply_valid_i = 1'b0;
    reply_last_i = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #1 sys_rst_i = 1'b0;
    check(lane0_lp_oe_o, 1'b0);
    t_burst();
    t_escape();
    t_turn();
    print_verdict();
  end
endmodule : tb_serial_display_link_control
bind serial_display_link_control link_ctrl_properties #(.NUM_LANES(NUM_LANES))
  link_ctrl_properties_inst (.*);
